// File: ast_pkg.sv
// constants and types for the async serial transceiver
package ast_pkg;
   localparam int FIFO_DEPTH = 4;
   localparam int RX_W = 11;
   localparam logic [15:0] DIV_RESET = 16'h0000;
   localparam logic [4:0] TICKS_STD = 5'h10;
   localparam logic [4:0] TICKS_HS = 5'h04;
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_9 = 4'h9;
   localparam logic [3:0] BREAK_ZEROS = 4'hc;
   localparam logic [1:0] FMT_8N = 2'h0;
   localparam logic [1:0] FMT_8E = 2'h1;
   localparam logic [1:0] FMT_8O = 2'h2;
   localparam logic [1:0] FMT_9N = 2'h3;
   localparam logic [1:0] TXI_EACH = 2'h0;
   localparam logic [1:0] TXI_DONE = 2'h1;
   localparam logic [1:0] TXI_EMPTY = 2'h2;
   localparam logic [1:0] RXI_3 = 2'h2;
   localparam logic [1:0] RXI_4 = 2'h3;
   localparam logic [2:0] LVL_BEFORE_3 = 3'h2;
   localparam logic [2:0] LVL_BEFORE_4 = 3'h3;
   localparam logic [1:0] PIN_NONE = 2'h0;
   localparam logic [1:0] PIN_RTS_CTS = 2'h2;
   localparam logic [1:0] PIN_BCLK = 2'h3;
   localparam logic [2:0] SYNC_EDGES = 3'h5;
   localparam int AB_SHIFT_STD = 7;
   localparam int AB_SHIFT_HS = 5;
   typedef struct packed {
      logic enable;
      logic high_speed_baud_select;
      logic [1:0] frame_format_select;
      logic two_stop;
      logic loopback;
      logic address_detect;
      logic [1:0] tx_interrupt_select;
      logic [1:0] rx_interrupt_select;
      logic [1:0] pin_usage_select;
      logic rts_simplex;
      logic transmit_enable_bit;
   } ast_cfg_t;
   typedef struct packed {
      logic [8:0] data;
      logic parity_error_flag;
      logic framing_error_flag;
   } ast_rx_word_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_WAIT = 3'b001, S_START = 3'b010,
      S_DATA = 3'b011, S_PARITY = 3'b100, S_STOP = 3'b101
   } ast_state_t;
endpackage

// File: ast_transceiver.sv
// async serial transceiver: baud timer, tx/rx engines, fifos
// Function
// - baud timer is a free-running 16-bit counter, period set by divisor
// - high-speed select clear: bit rate is clock over 16 times divisor+1
// - high-speed select set: bit rate is clock over 4 times divisor+1
// - writing the divisor clears the baud timer at once
// - setting transmit enable raises a transmit interrupt two cycles later
// - 8-bit: written byte moves to shifter, shifting starts next baud tick
// - data loaded while disabled starts once enable is set, timer cleared
// - 9-bit mode: only whole-word writes load all nine bits
// - break header: dummy char ignored, break sent, then sync byte follows
// - receive interrupt when fill level meets receive interrupt select
// - overrun flag stays set until software clears it
// - reading receive data advances fifo with that char's own error flags
// - transmit and receive fifos are each four characters deep
// - 8 or 9 data bits, parity only for 8-bit, one or two stops
// - 9-bit address detect: ninth bit one marks an address character
// - receiver flags parity, framing and overrun errors
// - sixteen-times clock modes work only with high-speed select clear
// - pin usage 11 and enabled: baud clock drives the shared rts pin
// - cts/rts give simplex and flow control, set by pin usage
// - loopback routes transmitted data back into the receiver
// - automatic baud detection from a received sync character
// - tx interrupt: 00 each load, 01 all shifted out, 10 load empties fifo
// - rx interrupt: 11 at four chars, 10 at three, 0x every char
// - format: 11 9-bit, 10 odd parity, 01 even parity, 00 none
// - break is start, twelve zeros, stop, then send break self-clears
`timescale 1ns/100ps
module ast_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out,
   output logic [$clog2(DEPTH+1)-1:0] count_out
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic push, pop;
   // honest full/empty straight from the count
   assign in_ready_out = (cnt_reg != CW'(DEPTH));
   assign out_valid_out = (cnt_reg != '0);
   assign out_data_out = mem[rd_reg];
   assign count_out = cnt_reg;
   assign push = in_valid_in & in_ready_out & !flush_in;
   assign pop = out_valid_out & out_ready_in & !flush_in;
   // pointer and count update
   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg + CW'(push) - CW'(pop);
      if (push) begin
         wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
         rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      if (flush_in) begin
         wr_next = '0;
         rd_next = '0;
         cnt_next = '0;
      end
   end
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end
   // storage carries no reset, only written on push
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_reg] <= in_data_in;
      end
   end
endmodule

module ast_transceiver (
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire ast_pkg::ast_cfg_t CFG_IN,
   input wire logic [15:0] BAUD_DIVISOR_IN,
   input wire logic BAUD_DIVISOR_WR_IN,
   output logic [15:0] BAUD_DIVISOR_OUT,
   input wire logic AUTO_BAUD_START_IN,
   output logic AUTO_BAUD_BUSY_OUT,
   input wire logic SEND_BREAK_SET_IN,
   output logic SEND_BREAK_OUT,
   input wire logic [8:0] TX_DATA_IN,
   input wire logic TX_VALID_IN,
   input wire logic TX_WORD_IN,
   output logic TX_READY_OUT,
   output logic TX_SHIFT_EMPTY_OUT,
   output logic TX_INT_OUT,
   output ast_pkg::ast_rx_word_t RX_DATA_OUT,
   output logic RX_VALID_OUT,
   input wire logic RX_READ_IN,
   output logic RX_INT_OUT,
   output logic OVERRUN_ERROR_OUT,
   input wire logic OVERRUN_CLEAR_IN,
   input wire logic SERIAL_IN_PIN_IN,
   output logic SERIAL_OUT_PIN_OUT,
   output logic SERIAL_OUT_OE_OUT,
   input wire logic CLEAR_TO_SEND_N_IN,
   output logic REQUEST_TO_SEND_N_OUT,
   output logic REQUEST_TO_SEND_OE_OUT
);
   import ast_pkg::*;
   logic [15:0] div_reg, div_next, cnt_reg, cnt_next, ab_div;
   logic bclk_reg, bclk_next, tick, restart, nine, txen, txen_q_reg;
   logic [4:0] tpb;
   ast_state_t tx_reg, tx_next, rx_reg, rx_next;
   logic [8:0] tsh_reg, tsh_next, rsh_reg, rsh_next;
   logic [4:0] tsub_reg, tsub_next, rsub_reg, rsub_next;
   logic [3:0] tbit_reg, tbit_next, rbit_reg, rbit_next, tnbits;
   logic tline_reg, tline_next, tpar_reg, tpar_next, tbrk_reg, tbrk_next;
   logic brk_reg, brk_next, rise_reg, tint_reg, tint_next, tdone;
   logic rts_reg, rts_next, tpop, tvalid, tin_rdy, tend, tlast, cts_ok;
   logic [8:0] tdata;
   logic [2:0] tcount, rcount, edges_reg, edges_next;
   logic rline, rprev_reg, fall, rend, rpar_reg, rpar_next, rstop;
   logic rin_rdy, rpush, rint_reg, rint_next, ov_reg, ov_next, ab_reg;
   logic ab_next, ab_done, ab_run_reg, ab_run_next, addr_ok;
   logic [23:0] abc_reg, abc_next, ab_q;
   ast_rx_word_t rword;

   assign nine = (CFG_IN.frame_format_select == FMT_9N);
   assign txen = CFG_IN.enable & CFG_IN.transmit_enable_bit;
   // ticks per bit: 16 standard, 4 high speed
   assign tpb = CFG_IN.high_speed_baud_select ? TICKS_HS : TICKS_STD;
   // a new divisor or a fresh enable restarts the timer from zero
   assign restart = BAUD_DIVISOR_WR_IN | ab_done
      | (txen & !txen_q_reg);
   assign tick = (cnt_reg == div_reg);
   assign ab_q = CFG_IN.high_speed_baud_select ? (abc_reg >> AB_SHIFT_HS)
      : (abc_reg >> AB_SHIFT_STD);
   assign ab_div = (ab_q == '0) ? DIV_RESET : ab_q[15:0] - 16'h0001;

   // baud timer and sixteen-times clock for the shared rts pin
   always_comb begin
      div_next = div_reg;
      if (BAUD_DIVISOR_WR_IN) begin
         div_next = BAUD_DIVISOR_IN;
      end else if (ab_done) begin
         div_next = ab_div;
      end
      cnt_next = (restart | tick) ? '0 : cnt_reg + 16'h0001;
      bclk_next = (cnt_next <= {1'b0, div_reg[15:1]});
   end
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         div_reg <= DIV_RESET;
         cnt_reg <= '0;
         bclk_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         cnt_reg <= cnt_next;
         bclk_reg <= bclk_next;
      end
   end

   // loads are taken while disabled; 9-bit mode takes word writes only
   ast_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txq (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .flush_in(txen_q_reg & !txen),
      .in_valid_in(TX_VALID_IN & (!nine | TX_WORD_IN)),
      .in_ready_out(tin_rdy),
      .in_data_in(TX_DATA_IN),
      .out_valid_out(tvalid),
      .out_ready_in(tpop),
      .out_data_out(tdata),
      .count_out(tcount)
   );
   assign TX_READY_OUT = tin_rdy & CFG_IN.enable;
   // cts gates only the start of a new character
   assign cts_ok = (CFG_IN.pin_usage_select != PIN_RTS_CTS)
      | !CLEAR_TO_SEND_N_IN;
   assign tpop = (tx_reg == S_IDLE) & tvalid & txen & cts_ok;
   assign tend = tick & (tsub_reg == tpb - 5'h01);
   assign tnbits = tbrk_reg ? BREAK_ZEROS : (nine ? BITS_9 : BITS_8);
   assign tlast = (tbit_reg == tnbits - 4'h1);
   assign tdone = (tx_reg == S_STOP) & tend
      & (tbit_reg == {3'h0, CFG_IN.two_stop & !tbrk_reg});

   // transmit engine
   always_comb begin
      tx_next = tx_reg;
      tsh_next = tsh_reg;
      tsub_next = tick ? tsub_reg + 5'h01 : tsub_reg;
      tbit_next = tbit_reg;
      tline_next = tline_reg;
      tpar_next = tpar_reg;
      tbrk_next = tbrk_reg;
      brk_next = brk_reg | SEND_BREAK_SET_IN;
      if (tend) begin
         tsub_next = '0;
      end
      unique case (tx_reg)
         S_IDLE: begin
            tline_next = 1'b1;
            if (tpop) begin
               tx_next = S_WAIT;
               tsh_next = nine ? tdata : {1'b0, tdata[7:0]};
               // even parity bit is data xor, odd its inverse
               tpar_next = ^tdata[7:0]
                  ^ (CFG_IN.frame_format_select == FMT_8O);
               tbrk_next = brk_reg; // dummy character is dropped
            end
         end
         S_WAIT: begin
            if (tick) begin
               tx_next = S_START;
               tline_next = 1'b0;
               tsub_next = '0;
            end
         end
         S_START: begin
            if (tend) begin
               tx_next = S_DATA;
               tbit_next = '0;
               tline_next = tbrk_reg ? 1'b0 : tsh_reg[0];
            end
         end
         S_DATA: begin
            if (tend) begin
               tsh_next = {1'b0, tsh_reg[8:1]};
               tbit_next = tbit_reg + 4'h1;
               tline_next = tbrk_reg ? 1'b0 : tsh_reg[1]; // lsb first
               if (tlast) begin
                  tbit_next = '0;
                  if (!tbrk_reg & !nine
                     & (CFG_IN.frame_format_select != FMT_8N)) begin
                     tx_next = S_PARITY;
                     tline_next = tpar_reg;
                  end else begin
                     tx_next = S_STOP;
                     tline_next = 1'b1;
                  end
               end
            end
         end
         S_PARITY: begin
            if (tend) begin
               tx_next = S_STOP;
               tline_next = 1'b1;
            end
         end
         S_STOP: begin
            if (tdone) begin
               tx_next = S_IDLE;
               if (tbrk_reg) begin
                  brk_next = SEND_BREAK_SET_IN; // a new set wins the clear
                  tbrk_next = 1'b0;
               end
            end else if (tend) begin
               tbit_next = tbit_reg + 4'h1;
            end
         end
         default: tx_next = S_IDLE;
      endcase
      if (!txen) begin
         tx_next = S_IDLE; // disabling aborts the frame
         tline_next = 1'b1;
         tbrk_next = 1'b0;
      end
   end
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         tx_reg <= S_IDLE;
         tsh_reg <= '0;
         tsub_reg <= '0;
         tbit_reg <= '0;
         tline_reg <= 1'b1;
         tpar_reg <= 1'b0;
         tbrk_reg <= 1'b0;
         brk_reg <= 1'b0;
      end else begin
         tx_reg <= tx_next;
         tsh_reg <= tsh_next;
         tsub_reg <= tsub_next;
         tbit_reg <= tbit_next;
         tline_reg <= tline_next;
         tpar_reg <= tpar_next;
         tbrk_reg <= tbrk_next;
         brk_reg <= brk_next;
      end
   end

   // transmit interrupt, rts and enable history
   always_comb begin
      tint_next = rise_reg;
      unique case (CFG_IN.tx_interrupt_select)
         TXI_EACH: tint_next = tint_next | tpop;
         TXI_DONE: tint_next = tint_next | (tdone & !tvalid);
         TXI_EMPTY: tint_next = tint_next | (tpop & (tcount == 3'h1));
         default: tint_next = tint_next;
      endcase
      // simplex asserts while sending, flow control while room remains
      rts_next = CFG_IN.rts_simplex ? (tx_next == S_IDLE)
         : !rin_rdy;
   end
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         txen_q_reg <= 1'b0;
         rise_reg <= 1'b0;
         tint_reg <= 1'b0;
         rts_reg <= 1'b1;
      end else begin
         txen_q_reg <= txen;
         rise_reg <= txen & !txen_q_reg;
         tint_reg <= tint_next;
         rts_reg <= rts_next;
      end
   end

   // loopback feeds the transmit line straight back
   assign rline = CFG_IN.loopback ? tline_reg : SERIAL_IN_PIN_IN;
   assign fall = rprev_reg & !rline;
   assign rend = tick & (rsub_reg == tpb - 5'h01);
   assign rstop = (rx_reg == S_STOP) & rend;
   assign addr_ok = !(CFG_IN.address_detect & nine
      & !rsh_reg[8]);
   assign rword.data = nine ? rsh_reg : {1'b0, rsh_reg[8:1]};
   // parity bit folded into the running xor leaves zero on a good frame
   assign rword.parity_error_flag = (CFG_IN.frame_format_select != FMT_8N)
      & !nine & rpar_reg;
   assign rword.framing_error_flag = !rline;
   assign rpush = rstop & addr_ok & !ab_reg;
   assign ab_done = ab_run_reg & fall & (edges_reg == SYNC_EDGES - 3'h1);

   // receive engine, sampling at bit centres
   always_comb begin
      rx_next = rx_reg;
      rsh_next = rsh_reg;
      rsub_next = tick ? rsub_reg + 5'h01 : rsub_reg;
      rbit_next = rbit_reg;
      rpar_next = rpar_reg;
      if (rend) begin
         rsub_next = '0;
      end
      unique case (rx_reg)
         S_IDLE: begin
            rsub_next = '0;
            if (fall & !ab_reg) begin
               rx_next = S_START;
            end
         end
         S_START: begin
            if (tick & (rsub_reg == (tpb >> 1) - 5'h01)) begin
               rsub_next = '0;
               rbit_next = '0;
               rpar_next = (CFG_IN.frame_format_select == FMT_8O);
               rx_next = rline ? S_IDLE : S_DATA; // glitch rejected
            end
         end
         S_DATA: begin
            if (rend) begin
               rsh_next = {rline, rsh_reg[8:1]};
               rpar_next = rpar_reg ^ rline;
               rbit_next = rbit_reg + 4'h1;
               if (rbit_reg == (nine ? BITS_9 : BITS_8) - 4'h1) begin
                  rx_next = (!nine & (CFG_IN.frame_format_select != FMT_8N))
                     ? S_PARITY : S_STOP;
               end
            end
         end
         S_PARITY: begin
            if (rend) begin
               rpar_next = rpar_reg ^ rline;
               rx_next = S_STOP;
            end
         end
         S_STOP: begin
            if (rend) begin
               rx_next = S_IDLE;
            end
         end
         default: rx_next = S_IDLE;
      endcase
      if (!CFG_IN.enable) begin
         rx_next = S_IDLE;
      end
   end
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rx_reg <= S_IDLE;
         rsh_reg <= '0;
         rsub_reg <= '0;
         rbit_reg <= '0;
         rpar_reg <= 1'b0;
         rprev_reg <= 1'b1;
      end else begin
         rx_reg <= rx_next;
         rsh_reg <= rsh_next;
         rsub_reg <= rsub_next;
         rbit_reg <= rbit_next;
         rpar_reg <= rpar_next;
         rprev_reg <= rline;
      end
   end

   ast_fifo #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH)) u_rxq (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .flush_in(!CFG_IN.enable),
      .in_valid_in(rpush),
      .in_ready_out(rin_rdy),
      .in_data_in(rword),
      .out_valid_out(RX_VALID_OUT),
      .out_ready_in(RX_READ_IN),
      .out_data_out(RX_DATA_OUT),
      .count_out(rcount)
   );

   // receive interrupt, overrun and sync measurement
   always_comb begin
      rint_next = rpush & rin_rdy;
      unique case (CFG_IN.rx_interrupt_select)
         RXI_3: rint_next = rint_next & (rcount == LVL_BEFORE_3);
         RXI_4: rint_next = rint_next & (rcount == LVL_BEFORE_4);
         default: rint_next = rint_next;
      endcase
      // a new overrun wins over a clear in the same cycle
      ov_next = (rpush & !rin_rdy)
         | (ov_reg & !OVERRUN_CLEAR_IN);
      ab_next = (ab_reg | AUTO_BAUD_START_IN) & !ab_done;
      ab_run_next = ab_run_reg;
      edges_next = edges_reg;
      abc_next = ab_run_reg ? abc_reg + 24'h000001 : '0;
      if (ab_reg & fall) begin
         ab_run_next = !ab_done;
         edges_next = ab_done ? '0 : edges_reg + 3'h1;
      end
      if (!ab_reg) begin
         ab_run_next = 1'b0;
         edges_next = '0;
      end
   end
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rint_reg <= 1'b0;
         ov_reg <= 1'b0;
         ab_reg <= 1'b0;
         ab_run_reg <= 1'b0;
         edges_reg <= '0;
         abc_reg <= '0;
      end else begin
         rint_reg <= rint_next;
         ov_reg <= ov_next;
         ab_reg <= ab_next;
         ab_run_reg <= ab_run_next;
         edges_reg <= edges_next;
         abc_reg <= abc_next;
      end
   end

   // outputs; baud clock only while sixteen-times mode is in use
   assign BAUD_DIVISOR_OUT = div_reg;
   assign AUTO_BAUD_BUSY_OUT = ab_reg;
   assign SEND_BREAK_OUT = brk_reg;
   assign TX_SHIFT_EMPTY_OUT = (tx_reg == S_IDLE) & !tvalid;
   assign TX_INT_OUT = tint_reg;
   assign RX_INT_OUT = rint_reg;
   assign OVERRUN_ERROR_OUT = ov_reg;
   assign SERIAL_OUT_PIN_OUT = tline_reg;
   assign SERIAL_OUT_OE_OUT = txen;
   assign REQUEST_TO_SEND_N_OUT = (CFG_IN.pin_usage_select == PIN_BCLK)
      ? (bclk_reg & !CFG_IN.high_speed_baud_select)
      : rts_reg;
   assign REQUEST_TO_SEND_OE_OUT = CFG_IN.enable
      & (CFG_IN.pin_usage_select != PIN_NONE);

   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   sequence brk_end_s;
      tdone && tbrk_reg;
   endsequence
   sequence rise_s;
      txen && !txen_q_reg;
   endsequence
   div_write_clear_a: assert property (BAUD_DIVISOR_WR_IN |=>
      cnt_reg == 16'h0000) else $error("divisor write did not clear timer");
   timer_period_a: assert property (tick && !restart && div_reg != '0
      |=> !tick) else $error("baud tick too early");
   txen_int_a: assert property (rise_s |-> ##2 TX_INT_OUT)
      else $error("no tx interrupt two cycles after enable");
   tx_load_wait_a: assert property (tpop |=> tx_reg == S_WAIT)
      else $error("load did not reach shifter");
   break_clear_a: assert property (brk_end_s |=> !brk_reg ||
      $past(SEND_BREAK_SET_IN)) else $error("send break not cleared");
   overrun_hold_a: assert property (ov_reg && !OVERRUN_CLEAR_IN
      |=> ov_reg) else $error("overrun cleared by hardware");
   rx_int_each_a: assert property (rpush && rin_rdy
      && !CFG_IN.rx_interrupt_select[1] |=> RX_INT_OUT)
      else $error("missing rx interrupt");
   txq_depth_a: assert property (!tin_rdy |-> tcount == 3'h4)
      else $error("tx fifo full at wrong depth");
   bclk_hs_off_a: assert property (CFG_IN.high_speed_baud_select
      && CFG_IN.pin_usage_select == PIN_BCLK |-> !REQUEST_TO_SEND_N_OUT)
      else $error("baud clock driven in high speed mode");
endmodule

// File: ast_remote.sv
// remote serial device model facing the transceiver line
`timescale 1ns/100ps
module ast_remote #(
   parameter int BIT = 32
) (
   input wire logic clk_in,
   input wire logic line_in,
   output logic line_out,
   output logic [7:0] got_out,
   output int got_n_out
);
   // line released high between frames, as a pulled-up wire would
   initial begin
      line_out = 1'b1;
      got_n_out = 0;
   end
   // low start, lsb first, chosen stop level
   task automatic send(input logic [7:0] b, input logic stop);
      for (int i = 0; i < 10; i++) begin
         line_out <= (i == 0) ? 1'b0 : (i == 9) ? stop : b[i-1];
         repeat (BIT) @(negedge clk_in);
      end
      line_out <= 1'b1;
      repeat (BIT) @(negedge clk_in);
   endtask
   // centre sampling from the start edge; wrong rate garbles data
   always begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk_in);
         got_out[i] = line_in;
      end
      got_n_out++;
      repeat (BIT) @(posedge clk_in);
   end
endmodule

// File: ast_transceiver_tb.sv
// self-checking bench for the async serial transceiver
`timescale 1ns/100ps
module ast_transceiver_tb;
   import ast_pkg::*;
   logic clk, rstn, div_wr, tx_v, rd, o_clr, tx_int, ovr, rx_v, so, oe;
   logic brk, brk_q;
   logic [15:0] div, div_q;
   logic [7:0] b, got, q[$];
   ast_cfg_t cfg;
   ast_rx_word_t rx_w;
   wire logic rx_line;
   wire logic line = oe ? so : 1'b1;
   int got_n, n_mismatch, tests_run, seed;
   ast_transceiver ast_transceiver_inst (.CLK_IN(clk), .RSTN_IN(rstn),
      .CFG_IN(cfg), .BAUD_DIVISOR_IN(div), .BAUD_DIVISOR_WR_IN(div_wr),
      .BAUD_DIVISOR_OUT(div_q), .AUTO_BAUD_START_IN(1'b0),
      .AUTO_BAUD_BUSY_OUT(), .SEND_BREAK_SET_IN(brk), .SEND_BREAK_OUT(brk_q),
      .TX_DATA_IN({1'b0, b}), .TX_VALID_IN(tx_v), .TX_WORD_IN(1'b0),
      .TX_READY_OUT(), .TX_SHIFT_EMPTY_OUT(), .TX_INT_OUT(tx_int),
      .RX_DATA_OUT(rx_w), .RX_VALID_OUT(rx_v), .RX_READ_IN(rd),
      .RX_INT_OUT(), .OVERRUN_ERROR_OUT(ovr), .OVERRUN_CLEAR_IN(o_clr),
      .SERIAL_IN_PIN_IN(rx_line), .SERIAL_OUT_PIN_OUT(so),
      .SERIAL_OUT_OE_OUT(oe), .CLEAR_TO_SEND_N_IN(1'b0),
      .REQUEST_TO_SEND_N_OUT(), .REQUEST_TO_SEND_OE_OUT());
   ast_remote #(.BIT(32)) ast_remote_inst (.clk_in(clk), .line_in(line),
      .line_out(rx_line), .got_out(got), .got_n_out(got_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic wrap_up;
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bounded wait for the remote to count a frame
   task automatic wait_got(input int target);
      for (int i = 0; i < 4000 && got_n < target; i++) @(negedge clk);
      if (got_n < target) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   // divisor write, then random bytes out; rate set by divisor
   task automatic tx_burst(input logic [15:0] d);
      div = d;
      div_wr = 1'b1;
      @(negedge clk);
      div_wr = 1'b0;
      chk(div_q, d);
      q.delete();
      for (int k = 0; k < 3; k++) begin
         b = $urandom;
         q.push_back(b);
         tx_v = 1'b1;
         @(negedge clk);
      end
      tx_v = 1'b0;
      for (int k = 0; k < 3; k++) begin
         wait_got(got_n + 1);
         chk(got, q[k]);
      end
   endtask
   initial begin
      {cfg, div, div_wr, tx_v, rd, o_clr, b, rstn, brk} = '0;
      seed = $urandom(32'hc928);
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      chk(so, 1'b1);
      cfg.enable = 1'b1;
      @(negedge clk);
      cfg.transmit_enable_bit = 1'b1;
      for (int i = 1; i <= 3; i++) begin
         @(negedge clk);
         chk(tx_int, i == 2);
      end
      tx_burst(16'h0001);
      cfg.high_speed_baud_select = 1'b1;
      tx_burst(16'h0007);
      // break header: random dummy is dropped, twelve zeros, then sync
      brk = 1'b1;
      @(negedge clk);
      brk = 1'b0;
      chk(brk_q, 1'b1);
      b = $urandom;
      tx_v = 1'b1;
      @(negedge clk);
      b = 8'h55;
      @(negedge clk);
      tx_v = 1'b0;
      wait_got(got_n + 1);
      chk(got, 8'h00);
      wait_got(got_n + 1);
      chk(got, 8'h55);
      chk(brk_q, 1'b0);
      // five frames into a four-deep fifo with no reads
      q.delete();
      for (int k = 0; k < 5; k++) begin
         b = $urandom;
         q.push_back(b);
         ast_remote_inst.send(b, 1'b1);
      end
      repeat (50) @(negedge clk);
      chk(ovr, 1'b1);
      for (int k = 0; k < 4; k++) begin
         chk(rx_w, {1'b0, q[k], 2'b00});
         rd = 1'b1;
         @(negedge clk);
         rd = 1'b0;
         @(negedge clk);
      end
      chk(rx_v, 1'b0);
      chk(ovr, 1'b1);
      o_clr = 1'b1;
      @(negedge clk);
      o_clr = 1'b0;
      chk(ovr, 1'b0);
      ast_remote_inst.send(8'ha5, 1'b0);
      chk(rx_w, {9'h0a5, 2'b01});
      wrap_up();
   end
endmodule
